// file: common/scm_pkg.sv
// Constants and types for the system clock and operating-mode controller.
// Assumes a single 200 MHz system clock and an AXI4-Lite register bus.
package scm_pkg;
	localparam int unsigned CLK_MHZ = 200;
	// Register byte offsets
	localparam logic [4:0] OFS_SYS_CTRL_ONE = 5'h00;
	localparam logic [4:0] OFS_SYS_CTRL_TWO = 5'h04;
	localparam logic [4:0] OFS_TIMEBASE_CTRL = 5'h08;
	localparam logic [4:0] OFS_MODE_STATUS = 5'h0C;
	localparam logic [4:0] OFS_DIVIDER = 5'h10;
	// Reset values
	localparam logic [7:0] RST_SYS_CTRL_ONE = 8'h00;
	localparam logic [7:0] RST_SYS_CTRL_TWO = 8'h80;
	localparam logic [7:0] RST_TIMEBASE_CTRL = 8'h00;
	// system_control_one fields
	localparam int unsigned B_STOP_REQ = 7;
	localparam int unsigned B_STOP_EDGE = 6;
	localparam int unsigned B_WARMUP_LO = 3;
	// system_control_two fields
	localparam int unsigned B_HIGH_OSC_EN = 7;
	localparam int unsigned B_LOW_OSC_EN = 6;
	localparam int unsigned B_MAIN_SRC_SEL = 5;
	localparam int unsigned B_IDLE = 4;
	localparam int unsigned B_TG_HALT = 2;
	// timebase_control fields
	localparam int unsigned B_TB_ENABLE = 7;
	localparam int unsigned B_DV7_SRC = 4;
	localparam int unsigned B_TB_SEL_LO = 0;
	// Divider geometry
	localparam int unsigned PRESCALER_BITS = 2;
	localparam int unsigned DIVIDER_BITS = 21;
	localparam int unsigned LOW_STAGES = 6;
	localparam logic [1:0] MCYCLE_LAST = 2'h3;
	// Divider taps for timebase source and warm-up end
	localparam logic [4:0] TB_TAP [8] = '{5'h14, 5'h12, 5'h0D, 5'h0B, 5'h0A, 5'h09, 5'h08, 5'h07};
	localparam logic [4:0] WU_TAP [4] = '{5'h14, 5'h13, 5'h12, 5'h11};
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [11:0] {
		M_FAST_SINGLE_RUN = 12'h001,
		M_FAST_SINGLE_IDLE = 12'h002,
		M_TIMEBASE_ONLY_IDLE = 12'h004,
		M_FAST_DUAL_RUN = 12'h008,
		M_FAST_DUAL_IDLE = 12'h010,
		M_DUAL_OSC_SLOW = 12'h020,
		M_DUAL_OSC_SLEEP = 12'h040,
		M_LOW_ONLY_SLOW = 12'h080,
		M_LOW_ONLY_SLEEP = 12'h100,
		M_LOW_TIMEBASE_SLEEP = 12'h200,
		M_STOP = 12'h400,
		M_WARMUP = 12'h800
	} scm_mode_t;
endpackage

// file: core/scm_controller.sv
// System clock timing generator and operating-mode controller.
// Assumes fc_tick and fs_tick are one-cycle pulses, one per oscillator period,
// synchronous to mclk; cpu, peripheral and watchdog clocks are one-cycle enables, timebase_clk follows a divider bit.
// Summary of operation
// - Prescaler, 21-stage divider, machine cycle counter.
// - Produce main, divider, timebase, watchdog, timer clocks.
// - Stage seven input follows mode and selects.
// - Clear divider on reset, stop entry, release.
// - Sequence oscillators and modes from control registers.
// - Single clock: fast only, low pins ports.
// - Reset lands in fast single run mode.
// - Idle bit enters fast single idle mode.
// - Any interrupt request wakes fast idle.
// - Wake services interrupt or resumes next instruction.
// - Halt bit selects timebase-only idle mode.
// - Gate clocks; restart on timebase source fall.
// - Timebase idle wakes to run, ignoring enable.
// - Timebase service needs three enables set.
// - Timebase latch set if enabled at entry.
// - Dual clock: both run, main clock switches.
// - Machine cycle is four main clock periods.
// - Reset keeps single clock operation.
// - Source select bit toggles slow and fast.
// - High enable swaps slows; low stages stop.
// - Stop halts oscillators; pin release; warm-up.
// - Low timebase sleep wakes to low slow.
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
module scm_controller
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Oscillator period pulses
	input wire logic fc_tick,
	input wire logic fs_tick,
	// Interrupt side
	input wire logic irq_request,
	input wire logic irq_master_enable,
	input wire logic timebase_irq_enable,
	input wire logic stop_release_pin,
	// Generated clock enables
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic watchdog_clk_en,
	output logic timebase_clk,
	output logic divider_output_pin_n,
	// Mode outputs
	output logic high_osc_on,
	output logic low_osc_on,
	output logic low_pins_as_port,
	output logic timebase_irq,
	output logic irq_service,
	output logic resume_next,
	// AXI4-Lite write
	input wire logic [31:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	// AXI4-Lite read
	input wire logic [31:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready
);
	typedef struct packed {
		scm_pkg::scm_mode_t mode;
		scm_pkg::scm_mode_t ret_mode;
		logic [scm_pkg::PRESCALER_BITS-1:0] pre;
		logic [scm_pkg::DIVIDER_BITS-1:0] div;
		logic [1:0] mcyc;
		logic [7:0] sys_ctrl_one;
		logic [7:0] sys_ctrl_two;
		logic [7:0] timebase_ctrl;
		logic tb_prev;
		logic stop_prev;
		logic tb_armed;
		logic aw_got;
		logic w_got;
		logic [4:0] waddr;
		logic [7:0] wdata;
		logic wlane;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic cpu_en;
		logic periph_en;
		logic wdt_en;
		logic tb_clk;
		logic dvo_n;
		logic hi_on;
		logic lo_on;
		logic pins_port;
		logic tb_irq;
		logic service;
		logic resume;
	} scm_state_t;

	scm_state_t st;
	scm_state_t next_st;
	scm_pkg::scm_mode_t eff;
	logic fast;
	logic main_tick;
	logic hi_run;
	logic pre_carry;
	logic carry6;
	logic stage7_in;
	logic mc_pulse;
	logic tb_now;
	logic tb_fall;
	logic released;
	logic enter_stop;

	function automatic logic is_fast(input scm_pkg::scm_mode_t m);
		is_fast = (m == scm_pkg::M_FAST_SINGLE_RUN) || (m == scm_pkg::M_FAST_SINGLE_IDLE)
			|| (m == scm_pkg::M_TIMEBASE_ONLY_IDLE) || (m == scm_pkg::M_FAST_DUAL_RUN)
			|| (m == scm_pkg::M_FAST_DUAL_IDLE);
	endfunction

	function automatic logic is_single(input scm_pkg::scm_mode_t m);
		is_single = (m == scm_pkg::M_FAST_SINGLE_RUN) || (m == scm_pkg::M_FAST_SINGLE_IDLE)
			|| (m == scm_pkg::M_TIMEBASE_ONLY_IDLE);
	endfunction

	function automatic logic is_low_only(input scm_pkg::scm_mode_t m);
		is_low_only = (m == scm_pkg::M_LOW_ONLY_SLOW) || (m == scm_pkg::M_LOW_ONLY_SLEEP)
			|| (m == scm_pkg::M_LOW_TIMEBASE_SLEEP);
	endfunction

	function automatic logic is_run(input scm_pkg::scm_mode_t m);
		is_run = (m == scm_pkg::M_FAST_SINGLE_RUN) || (m == scm_pkg::M_FAST_DUAL_RUN)
			|| (m == scm_pkg::M_DUAL_OSC_SLOW) || (m == scm_pkg::M_LOW_ONLY_SLOW);
	endfunction

	function automatic logic [31:0] read_reg(input scm_state_t s, input logic [4:0] a);
		case (a)
			scm_pkg::OFS_SYS_CTRL_ONE: read_reg = {24'h000000, s.sys_ctrl_one};
			scm_pkg::OFS_SYS_CTRL_TWO: read_reg = {24'h000000, s.sys_ctrl_two};
			scm_pkg::OFS_TIMEBASE_CTRL: read_reg = {24'h000000, s.timebase_ctrl};
			scm_pkg::OFS_MODE_STATUS: read_reg = {20'h00000, s.mode};
			scm_pkg::OFS_DIVIDER: read_reg = {9'h000, s.div, s.pre};
			default: read_reg = 32'h00000000;
		endcase
	endfunction

	function automatic logic mapped(input logic [31:0] a);
		mapped = (a[31:5] == 27'h0000000) && (a[1:0] == 2'h0) && (a[4:0] <= scm_pkg::OFS_DIVIDER);
	endfunction

	always_comb
	begin
		next_st = st;
		next_st.tb_irq = 1'b0;
		next_st.service = 1'b0;
		next_st.resume = 1'b0;
		// Warm-up counts on the clock of the mode it returns to
		eff = (st.mode == scm_pkg::M_WARMUP) ? st.ret_mode : st.mode;
		fast = is_fast(eff);
		main_tick = fast ? fc_tick : fs_tick;
		// Stages one to six idle whenever the fast oscillator is off
		hi_run = (st.mode != scm_pkg::M_STOP) && !is_low_only(eff);
		pre_carry = hi_run && fc_tick && (st.pre == 2'h3);
		carry6 = pre_carry && (st.div[scm_pkg::LOW_STAGES-1:0] == 6'h3F);
		if (!fast || (!is_single(eff) && st.timebase_ctrl[scm_pkg::B_DV7_SRC]))
		begin
			stage7_in = fs_tick;
		end
		else
		begin
			stage7_in = carry6;
		end
		if (hi_run && fc_tick)
		begin
			next_st.pre = st.pre + 2'h1;
		end
		if (pre_carry)
		begin
			next_st.div[5:0] = st.div[5:0] + 6'h01;
		end
		if (stage7_in && (st.mode != scm_pkg::M_STOP))
		begin
			next_st.div[20:6] = st.div[20:6] + 15'h0001;
		end
		// Machine cycle: four main clock periods
		mc_pulse = main_tick && (st.mcyc == scm_pkg::MCYCLE_LAST) && (st.mode != scm_pkg::M_STOP);
		if (main_tick && (st.mode != scm_pkg::M_STOP))
		begin
			next_st.mcyc = st.mcyc + 2'h1;
		end
		tb_now = st.div[scm_pkg::TB_TAP[st.timebase_ctrl[2:0]]];
		next_st.tb_prev = tb_now;
		tb_fall = st.tb_prev && !tb_now;
		next_st.stop_prev = stop_release_pin;
		if (st.sys_ctrl_one[scm_pkg::B_STOP_EDGE])
		begin
			released = stop_release_pin && !st.stop_prev;
		end
		else
		begin
			released = stop_release_pin;
		end
		enter_stop = st.sys_ctrl_one[scm_pkg::B_STOP_REQ];
		// Mode sequencing; the state only moves on mclk edges
		case (st.mode)
			scm_pkg::M_FAST_SINGLE_RUN:
			begin
				if (enter_stop)
				begin
					next_st.mode = scm_pkg::M_STOP;
					next_st.ret_mode = scm_pkg::M_FAST_SINGLE_RUN;
				end
				else if (st.sys_ctrl_two[scm_pkg::B_IDLE] && st.sys_ctrl_two[scm_pkg::B_TG_HALT])
				begin
					next_st.mode = scm_pkg::M_TIMEBASE_ONLY_IDLE;
					next_st.tb_armed = st.timebase_ctrl[scm_pkg::B_TB_ENABLE];
					next_st.sys_ctrl_two[scm_pkg::B_IDLE] = 1'b0;
				end
				else if (st.sys_ctrl_two[scm_pkg::B_IDLE])
				begin
					next_st.mode = scm_pkg::M_FAST_SINGLE_IDLE;
					next_st.sys_ctrl_two[scm_pkg::B_IDLE] = 1'b0;
				end
				else if (st.sys_ctrl_two[scm_pkg::B_LOW_OSC_EN])
				begin
					next_st.mode = scm_pkg::M_FAST_DUAL_RUN;
				end
			end
			scm_pkg::M_FAST_DUAL_RUN:
			begin
				if (enter_stop)
				begin
					next_st.mode = scm_pkg::M_STOP;
					next_st.ret_mode = scm_pkg::M_FAST_DUAL_RUN;
				end
				else if (st.sys_ctrl_two[scm_pkg::B_IDLE])
				begin
					next_st.mode = scm_pkg::M_FAST_DUAL_IDLE;
					next_st.sys_ctrl_two[scm_pkg::B_IDLE] = 1'b0;
				end
				else if (st.sys_ctrl_two[scm_pkg::B_MAIN_SRC_SEL])
				begin
					next_st.mode = scm_pkg::M_DUAL_OSC_SLOW;
				end
				else if (!st.sys_ctrl_two[scm_pkg::B_LOW_OSC_EN])
				begin
					next_st.mode = scm_pkg::M_FAST_SINGLE_RUN;
				end
			end
			scm_pkg::M_DUAL_OSC_SLOW:
			begin
				if (st.sys_ctrl_two[scm_pkg::B_IDLE])
				begin
					next_st.mode = scm_pkg::M_DUAL_OSC_SLEEP;
					next_st.sys_ctrl_two[scm_pkg::B_IDLE] = 1'b0;
				end
				else if (!st.sys_ctrl_two[scm_pkg::B_MAIN_SRC_SEL])
				begin
					next_st.mode = scm_pkg::M_FAST_DUAL_RUN;
				end
				else if (!st.sys_ctrl_two[scm_pkg::B_HIGH_OSC_EN])
				begin
					next_st.mode = scm_pkg::M_LOW_ONLY_SLOW;
				end
			end
			scm_pkg::M_LOW_ONLY_SLOW:
			begin
				if (enter_stop)
				begin
					next_st.mode = scm_pkg::M_STOP;
					next_st.ret_mode = scm_pkg::M_LOW_ONLY_SLOW;
				end
				else if (st.sys_ctrl_two[scm_pkg::B_IDLE] && st.sys_ctrl_two[scm_pkg::B_TG_HALT])
				begin
					next_st.mode = scm_pkg::M_LOW_TIMEBASE_SLEEP;
					next_st.tb_armed = st.timebase_ctrl[scm_pkg::B_TB_ENABLE];
					next_st.sys_ctrl_two[scm_pkg::B_IDLE] = 1'b0;
				end
				else if (st.sys_ctrl_two[scm_pkg::B_IDLE])
				begin
					next_st.mode = scm_pkg::M_LOW_ONLY_SLEEP;
					next_st.sys_ctrl_two[scm_pkg::B_IDLE] = 1'b0;
				end
				else if (st.sys_ctrl_two[scm_pkg::B_HIGH_OSC_EN])
				begin
					next_st.mode = scm_pkg::M_DUAL_OSC_SLOW;
				end
			end
			scm_pkg::M_FAST_SINGLE_IDLE, scm_pkg::M_FAST_DUAL_IDLE,
			scm_pkg::M_DUAL_OSC_SLEEP, scm_pkg::M_LOW_ONLY_SLEEP:
			begin
				if (irq_request)
				begin
					// Idle exits one step back to its run mode
					next_st.mode = scm_pkg::scm_mode_t'({st.mode[11:1], 1'b0} >> 1);
					next_st.service = irq_master_enable;
					next_st.resume = !irq_master_enable;
				end
			end
			scm_pkg::M_TIMEBASE_ONLY_IDLE, scm_pkg::M_LOW_TIMEBASE_SLEEP:
			begin
				if (tb_fall)
				begin
					if (st.mode == scm_pkg::M_TIMEBASE_ONLY_IDLE)
					begin
						next_st.mode = scm_pkg::M_FAST_SINGLE_RUN;
					end
					else
					begin
						next_st.mode = scm_pkg::M_LOW_ONLY_SLOW;
					end
					next_st.tb_irq = st.tb_armed;
					next_st.service = irq_master_enable && timebase_irq_enable
						&& st.timebase_ctrl[scm_pkg::B_TB_ENABLE];
					next_st.tb_armed = 1'b0;
				end
			end
			scm_pkg::M_STOP:
			begin
				if (released)
				begin
					next_st.mode = scm_pkg::M_WARMUP;
				end
			end
			scm_pkg::M_WARMUP:
			begin
				if (st.div[scm_pkg::WU_TAP[st.sys_ctrl_one[4:3]]])
				begin
					next_st.mode = st.ret_mode;
					next_st.sys_ctrl_one[scm_pkg::B_STOP_REQ] = 1'b0;
					next_st.resume = 1'b1;
				end
			end
			default:
			begin
				next_st.mode = scm_pkg::M_FAST_SINGLE_RUN;
			end
		endcase
		// Divider restarts from zero at stop entry and at release
		if ((st.mode != scm_pkg::M_STOP && next_st.mode == scm_pkg::M_STOP)
			|| (st.mode == scm_pkg::M_STOP && next_st.mode == scm_pkg::M_WARMUP))
		begin
			next_st.pre = '0;
			next_st.div = '0;
			next_st.tb_prev = 1'b0;
		end
		// Generated enables change only on machine-cycle boundaries
		next_st.cpu_en = mc_pulse && is_run(st.mode);
		next_st.wdt_en = mc_pulse && is_run(st.mode);
		next_st.periph_en = mc_pulse && (st.mode != scm_pkg::M_TIMEBASE_ONLY_IDLE)
			&& (st.mode != scm_pkg::M_LOW_TIMEBASE_SLEEP) && (st.mode != scm_pkg::M_WARMUP);
		next_st.tb_clk = tb_now;
		next_st.dvo_n = !st.div[scm_pkg::LOW_STAGES];
		next_st.hi_on = hi_run;
		next_st.lo_on = (st.mode != scm_pkg::M_STOP) && !is_single(eff);
		next_st.pins_port = is_single(eff);
		// AXI4-Lite write path: address and data in either order
		if (s_awvalid && st.awready)
		begin
			next_st.aw_got = 1'b1;
			next_st.waddr = s_awaddr[4:0];
			next_st.bresp = mapped(s_awaddr) ? scm_pkg::RESP_OKAY : scm_pkg::RESP_SLVERR;
		end
		if (s_wvalid && st.wready)
		begin
			next_st.w_got = 1'b1;
			next_st.wdata = s_wdata[7:0];
			next_st.wlane = s_wstrb[0];
		end
		if (st.aw_got && st.w_got && !st.bvalid)
		begin
			next_st.bvalid = 1'b1;
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			if (st.wlane && (st.bresp == scm_pkg::RESP_OKAY))
			begin
				case (st.waddr)
					scm_pkg::OFS_SYS_CTRL_ONE: next_st.sys_ctrl_one = st.wdata;
					scm_pkg::OFS_SYS_CTRL_TWO: next_st.sys_ctrl_two = st.wdata;
					scm_pkg::OFS_TIMEBASE_CTRL: next_st.timebase_ctrl = st.wdata;
					default: next_st.wdata = st.wdata;
				endcase
			end
		end
		if (st.bvalid && s_bready)
		begin
			next_st.bvalid = 1'b0;
		end
		next_st.awready = !next_st.aw_got && !next_st.bvalid && !(s_awvalid && st.awready);
		next_st.wready = !next_st.w_got && !next_st.bvalid && !(s_wvalid && st.wready);
		// AXI4-Lite read path
		if (s_arvalid && st.arready)
		begin
			next_st.rvalid = 1'b1;
			next_st.rdata = read_reg(st, s_araddr[4:0]);
			next_st.rresp = mapped(s_araddr) ? scm_pkg::RESP_OKAY : scm_pkg::RESP_SLVERR;
		end
		else if (st.rvalid && s_rready)
		begin
			next_st.rvalid = 1'b0;
		end
		next_st.arready = !next_st.rvalid;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.mode <= scm_pkg::M_FAST_SINGLE_RUN;
			st.ret_mode <= scm_pkg::M_FAST_SINGLE_RUN;
			st.sys_ctrl_one <= scm_pkg::RST_SYS_CTRL_ONE;
			st.sys_ctrl_two <= scm_pkg::RST_SYS_CTRL_TWO;
			st.timebase_ctrl <= scm_pkg::RST_TIMEBASE_CTRL;
			st.dvo_n <= 1'b1;
			st.hi_on <= 1'b1;
			st.pins_port <= 1'b1;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign cpu_clk_en = st.cpu_en;
	assign periph_clk_en = st.periph_en;
	assign watchdog_clk_en = st.wdt_en;
	assign timebase_clk = st.tb_clk;
	assign divider_output_pin_n = st.dvo_n;
	assign high_osc_on = st.hi_on;
	assign low_osc_on = st.lo_on;
	assign low_pins_as_port = st.pins_port;
	assign timebase_irq = st.tb_irq;
	assign irq_service = st.service;
	assign resume_next = st.resume;
	assign s_awready = st.awready;
	assign s_wready = st.wready;
	assign s_bvalid = st.bvalid;
	assign s_bresp = st.bresp;
	assign s_arready = st.arready;
	assign s_rvalid = st.rvalid;
	assign s_rdata = st.rdata;
	assign s_rresp = st.rresp;

	sequence idle_req_s;
		st.mode == scm_pkg::M_FAST_SINGLE_RUN && !enter_stop && st.sys_ctrl_two[scm_pkg::B_IDLE];
	endsequence

	sequence idle_wake_s;
		st.mode == scm_pkg::M_FAST_SINGLE_IDLE && irq_request;
	endsequence

	sequence tb_wake_s;
		st.mode == scm_pkg::M_TIMEBASE_ONLY_IDLE && tb_fall;
	endsequence

	mode_onehot_a: assert property (@(posedge mclk) disable iff (!rst_n) $onehot(st.mode))
		else $error("mode register not one-hot");
	idle_entry_a: assert property (@(posedge mclk) disable iff (!rst_n)
		idle_req_s |=> (st.mode == scm_pkg::M_FAST_SINGLE_IDLE)
			== !$past(st.sys_ctrl_two[scm_pkg::B_TG_HALT]))
		else $error("idle entry wrong");
	tb_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
		idle_req_s ##0 st.sys_ctrl_two[scm_pkg::B_TG_HALT]
			|=> st.mode == scm_pkg::M_TIMEBASE_ONLY_IDLE ##1 !cpu_clk_en && !periph_clk_en)
		else $error("timebase idle entry wrong");
	idle_wake_a: assert property (@(posedge mclk) disable iff (!rst_n)
		idle_wake_s |=> st.mode == scm_pkg::M_FAST_SINGLE_RUN
			&& irq_service == $past(irq_master_enable) && resume_next != irq_service)
		else $error("idle wake wrong");
	tb_wake_a: assert property (@(posedge mclk) disable iff (!rst_n)
		tb_wake_s |=> st.mode == scm_pkg::M_FAST_SINGLE_RUN && timebase_irq == $past(st.tb_armed))
		else $error("timebase wake wrong");
	stop_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(st.mode == scm_pkg::M_STOP) || $rose(st.mode == scm_pkg::M_WARMUP)
			|-> st.div == '0 && st.pre == '0)
		else $error("divider not cleared");
	low_stages_a: assert property (@(posedge mclk) disable iff (!rst_n)
		st.mode == scm_pkg::M_LOW_ONLY_SLOW ##1 st.mode == scm_pkg::M_LOW_ONLY_SLOW
			|-> $stable(st.pre) && $stable(st.div[5:0]) && !high_osc_on)
		else $error("low stages ran in low-only slow");
	slow_switch_a: assert property (@(posedge mclk) disable iff (!rst_n)
		st.mode == scm_pkg::M_FAST_DUAL_RUN && !enter_stop && !st.sys_ctrl_two[scm_pkg::B_IDLE]
			&& st.sys_ctrl_two[scm_pkg::B_MAIN_SRC_SEL] |=> st.mode == scm_pkg::M_DUAL_OSC_SLOW)
		else $error("slow switch missed");
	port_pins_a: assert property (@(posedge mclk) disable iff (!rst_n)
		st.mode == scm_pkg::M_FAST_DUAL_RUN |=> !low_pins_as_port && low_osc_on)
		else $error("low pins in port mode during dual clock");
endmodule // scm_controller

// file: verification/scm_cpu_model.sv
// Far-side model: oscillator period pulses and one interrupt source.
// Assumes the bench pulses irq_cmd; the request holds until a wake pulse takes it.
module scm_cpu_model
#(
	parameter int FC_DIV = 2,
	parameter int FS_DIV = 8
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// From the controller
	input wire logic high_osc_on,
	input wire logic low_osc_on,
	input wire logic irq_service,
	input wire logic resume_next,
	// From the bench
	input wire logic irq_cmd,
	// To the controller
	output logic fc_tick,
	output logic fs_tick,
	output logic irq_request
);
	timeunit 1ns;
	timeprecision 100ps;
	int fc_n;
	int fs_n;
	// A stopped oscillator gives no pulses
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fc_n <= 0;
			fs_n <= 0;
			fc_tick <= 1'b0;
			fs_tick <= 1'b0;
			irq_request <= 1'b0;
		end
		else
		begin
			fc_n <= (fc_n + 1) % FC_DIV;
			fs_n <= (fs_n + 1) % FS_DIV;
			fc_tick <= high_osc_on && fc_n == 0;
			fs_tick <= low_osc_on && fs_n == 0;
			if (irq_cmd)
				irq_request <= 1'b1;
			else if (irq_service || resume_next)
				irq_request <= 1'b0;
		end
	end
endmodule // scm_cpu_model

// file: verification/system_clock_mode_controller_test.sv
// Self-checking bench for the clock and mode controller.
// Assumes the far-side model supplies ticks and interrupts; registers over AXI4-Lite.
module system_clock_mode_controller_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk, rst_n, irq_cmd, irq_master_enable, timebase_irq_enable, stop_release_pin;
	logic fc_tick, fs_tick, irq_request, cpu_clk_en, periph_clk_en, watchdog_clk_en;
	logic timebase_clk, high_osc_on, low_osc_on, low_pins_as_port;
	logic timebase_irq, irq_service, resume_next, divider_output_pin_n;
	logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata, d;
	logic [3:0] s_wstrb;
	logic [1:0] s_bresp, s_rresp, r;
	logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic s_arvalid, s_arready, s_rvalid, s_rready;
	int mismatches, compares, cyc;
	int cnt [8];
	int base [8];
	wire logic [7:0] ev = {resume_next, irq_service, timebase_irq, periph_clk_en,
		watchdog_clk_en, cpu_clk_en, fs_tick, fc_tick};

	scm_controller scm_controller_i (.mclk, .rst_n, .fc_tick, .fs_tick, .irq_request,
		.irq_master_enable, .timebase_irq_enable, .stop_release_pin, .cpu_clk_en,
		.periph_clk_en, .watchdog_clk_en, .timebase_clk, .divider_output_pin_n,
		.high_osc_on, .low_osc_on, .low_pins_as_port, .timebase_irq, .irq_service,
		.resume_next, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
		.s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
		.s_rdata, .s_rresp, .s_rvalid, .s_rready);
	scm_cpu_model scm_cpu_model_i (.mclk, .rst_n, .high_osc_on, .low_osc_on, .irq_service,
		.resume_next, .irq_cmd, .fc_tick, .fs_tick, .irq_request);

	always #2.5 mclk = ~mclk;
	always @(posedge mclk)
		foreach (cnt[i])
			cnt[i] <= cnt[i] + int'(ev[i]);
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			mismatches++;
			test_done;
		end
	end

	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		logic b;
		b = 1'b1;
		s_awaddr <= {27'h0, a};
		s_wdata <= {24'h0, v};
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		while (b)
		begin
			@(posedge mclk);
			if (s_awready)
				s_awvalid <= 1'b0;
			if (s_wready)
				s_wvalid <= 1'b0;
			if (s_bvalid)
				b = 1'b0;
		end
		r = s_bresp;
	endtask
	task automatic rd(input logic [4:0] a);
		s_araddr <= {27'h0, a};
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (s_arready)
				s_arvalid <= 1'b0;
		end
		while (!s_rvalid);
		d = s_rdata;
		r = s_rresp;
	endtask
	task automatic wait_mode(input logic [11:0] m);
		int n;
		n = 0;
		do
		begin
			rd(scm_pkg::OFS_MODE_STATUS);
			n++;
		end
		while (d !== {20'h0, m} && n < 40);
		chk("mode", {20'h0, m}, d);
	endtask
	// Ticks of one source over four machine cycles
	task automatic mcyc(input int src);
		int s;
		do @(posedge mclk); while (!cpu_clk_en);
		s = cnt[src];
		repeat (4)
			do @(posedge mclk); while (!cpu_clk_en);
		chk("ticks per four cycles", 16, cnt[src] - s);
	endtask

	task automatic t_reset;
		wait_mode(scm_pkg::M_FAST_SINGLE_RUN);
		chk("low_pins_as_port", 1, low_pins_as_port);
		chk("low_osc_on", 0, low_osc_on);
		rd(scm_pkg::OFS_SYS_CTRL_TWO);
		chk("sys two", 32'h80, d);
		mcyc(0);
		rd(scm_pkg::OFS_DIVIDER);
		chk("divider_output_pin_n", {31'h0, !d[8]}, {31'h0, divider_output_pin_n});
		rd(5'h14);
		chk("unmapped read", {30'h0, scm_pkg::RESP_SLVERR}, {30'h0, r});
		wr(5'h14, 8'hFF);
		chk("unmapped write", {30'h0, scm_pkg::RESP_SLVERR}, {30'h0, r});
		$display("done reset");
	endtask
	task automatic t_idle;
		for (int i = 1; i >= 0; i--)
		begin
			irq_master_enable <= i[0];
			wr(scm_pkg::OFS_SYS_CTRL_TWO, 8'h90);
			wait_mode(scm_pkg::M_FAST_SINGLE_IDLE);
			base = cnt;
			repeat (40) @(posedge mclk);
			chk("cpu", 0, cnt[2] - base[2]);
			chk("watchdog", 0, cnt[3] - base[3]);
			chk("periph", 1, 32'(cnt[4] > base[4]));
			rd(scm_pkg::OFS_SYS_CTRL_TWO);
			chk("idle bit", 32'h80, d);
			base = cnt;
			irq_cmd <= 1'b1;
			@(posedge mclk);
			irq_cmd <= 1'b0;
			wait_mode(scm_pkg::M_FAST_SINGLE_RUN);
			chk("service", i, cnt[6] - base[6]);
			chk("resume", 1 - i, cnt[7] - base[7]);
		end
		$display("done idle");
	endtask
	task automatic t_tbidle;
		int n;
		irq_master_enable <= 1'b1;
		for (int en = 1; en >= 0; en--)
		begin
			wr(scm_pkg::OFS_TIMEBASE_CTRL, {en[0], 7'h07});
			do @(posedge mclk); while (!timebase_clk);
			do @(posedge mclk); while (timebase_clk);
			wr(scm_pkg::OFS_SYS_CTRL_TWO, 8'h94);
			wait_mode(scm_pkg::M_TIMEBASE_ONLY_IDLE);
			base = cnt;
			repeat (100) @(posedge mclk);
			chk("cpu", 0, cnt[2] - base[2]);
			chk("periph", 0, cnt[4] - base[4]);
			n = 0;
			while (cnt[5] == base[5] && n < 4000)
			begin
				@(posedge mclk);
				n++;
			end
			chk("timebase irq", en, cnt[5] - base[5]);
			chk("timebase service", en, cnt[6] - base[6]);
			wr(scm_pkg::OFS_SYS_CTRL_TWO, 8'h80);
			wait_mode(scm_pkg::M_FAST_SINGLE_RUN);
		end
		$display("done timebase idle");
	endtask
	task automatic t_dual;
		wr(scm_pkg::OFS_SYS_CTRL_TWO, 8'hC0);
		wait_mode(scm_pkg::M_FAST_DUAL_RUN);
		chk("low_pins_as_port", 0, low_pins_as_port);
		wr(scm_pkg::OFS_SYS_CTRL_TWO, 8'hE0);
		wait_mode(scm_pkg::M_DUAL_OSC_SLOW);
		mcyc(1);
		wr(scm_pkg::OFS_SYS_CTRL_TWO, 8'h60);
		wait_mode(scm_pkg::M_LOW_ONLY_SLOW);
		chk("high_osc_on", 0, high_osc_on);
		wr(scm_pkg::OFS_SYS_CTRL_TWO, 8'hE0);
		wait_mode(scm_pkg::M_DUAL_OSC_SLOW);
		wr(scm_pkg::OFS_SYS_CTRL_TWO, 8'hC0);
		wait_mode(scm_pkg::M_FAST_DUAL_RUN);
		mcyc(0);
		wr(scm_pkg::OFS_SYS_CTRL_TWO, 8'h80);
		wait_mode(scm_pkg::M_FAST_SINGLE_RUN);
		$display("done dual");
	endtask
	// Edge release first with the pin already high, then level release
	task automatic t_stop;
		for (int e = 1; e >= 0; e--)
		begin
			stop_release_pin <= e[0];
			wr(scm_pkg::OFS_SYS_CTRL_ONE, {1'b1, e[0], 6'h00});
			wait_mode(scm_pkg::M_STOP);
			chk("high_osc_on", 0, high_osc_on);
			rd(scm_pkg::OFS_DIVIDER);
			chk("divider", 0, d);
			chk("divider_output_pin_n", 1, divider_output_pin_n);
			repeat (20) @(posedge mclk);
			wait_mode(scm_pkg::M_STOP);
			stop_release_pin <= 1'b0;
			@(posedge mclk);
			stop_release_pin <= 1'b1;
			wait_mode(scm_pkg::M_WARMUP);
			stop_release_pin <= 1'b0;
			rst_n <= 1'b0;
			repeat (4) @(posedge mclk);
			rst_n <= 1'b1;
			repeat (2) @(posedge mclk);
			wait_mode(scm_pkg::M_FAST_SINGLE_RUN);
			chk("high_osc_on", 1, high_osc_on);
		end
		$display("done stop");
	endtask

	initial
	begin
		mclk = 1'b0;
		rst_n = 1'b0;
		{irq_cmd, irq_master_enable, stop_release_pin} = 3'h0;
		timebase_irq_enable = 1'b1;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
		{s_awaddr, s_wdata, s_araddr} = 96'h0;
		s_wstrb = 4'hF;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		t_reset;
		t_idle;
		t_tbidle;
		t_dual;
		t_stop;
		test_done;
	end
endmodule // system_clock_mode_controller_test
